/* hdl/cecab_regs.vh */
`ifndef CECAB_REGS_VH
`define CECAB_REGS_VH

// Register byte addresses
`define CECAB_ADDR_SEL_LO 16'hff2a
`define CECAB_ADDR_SEL_HI 16'hff2b
`define CECAB_ADDR_CTRL0 16'hff42
`define CECAB_ADDR_TXBUF 16'hff51
`define CECAB_ADDR_RXBUF 16'hff52
`define CECAB_ADDR_STAT 16'hff53

// Reset values
`define CECAB_RST_BYTE 8'h00
`define CECAB_RST_SEL 15'h0000
`define CECAB_RST_WORD 16'h0000

// Control register zero fields
`define CECAB_C0_ENABLE 7
`define CECAB_C0_ACKCHK 6
`define CECAB_C0_CLK_HI 5
`define CECAB_C0_CLK_LO 3
`define CECAB_C0_TXTRIG 2
`define CECAB_C0_RXACC 1
`define CECAB_C0_EOM 0

// Status register fields
`define CECAB_ST_UNDER 0
`define CECAB_ST_OVER 1
`define CECAB_ST_TXACT 2
`define CECAB_ST_RXFULL 3

// Byte framing
`define CECAB_BITS_LAST 4'h7
`define CECAB_CNT_ZERO 4'h0
`define CECAB_CNT_ONE 4'h1
`define CECAB_UNREG_ADDR 4'hf
`define CECAB_SEL_MSB 14

// FIFO shape
`define CECAB_FIFO_W 8
`define CECAB_FIFO_D 4
`define CECAB_FIFO_AW 2

`endif

/* hdl/cecab_fifo.v */
`timescale 1ns/1ps
`include "cecab_regs.vh"
module cecab_fifo #(
	parameter W = `CECAB_FIFO_W,
	parameter D = `CECAB_FIFO_D,
	parameter AW = `CECAB_FIFO_AW
) (
	input wire clk_i,
	input wire reset_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] mem_q [0:D-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	localparam integer LAST_I = D - 1;
	// Cut to the pointer and counter widths on purpose
	localparam [AW:0] DEPTH = D[AW:0];
	localparam [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};
	localparam [AW:0] CNT_ONE = {{AW{1'b0}}, 1'b1};
	localparam [AW-1:0] PTR_LAST = LAST_I[AW-1:0];

	// Full and empty straight from the occupancy count
	assign in_ready_o = (cnt_q != DEPTH);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o = mem_q[rp_q];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	////////////////////////////////////////////////////////////////
	// Storage, written by index
	genvar gi;
	generate
		for (gi = 0; gi < D; gi = gi + 1) begin : g_ent
			always @(posedge clk_i) begin
				if (reset_i) begin
					mem_q[gi] <= {W{1'b0}};
				end else if (push && wp_q == gi) begin
					mem_q[gi] <= in_data_i;
				end
			end
		end
	endgenerate

	// Pointers wrap at depth, not at a power of two
	always @(posedge clk_i) begin
		if (reset_i) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_q <= (wp_q == PTR_LAST) ? {AW{1'b0}} : wp_q + PTR_ONE;
			end
			if (pop) begin
				rp_q <= (rp_q == PTR_LAST) ? {AW{1'b0}} : rp_q + PTR_ONE;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + CNT_ONE;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - CNT_ONE;
			end
		end
	end
endmodule

/* hdl/cecab_top.v */
// Function
// - Select bit n of 0..14 set makes logical address n local.
// - Transmit byte shifted out most significant bit first, bit 7 to 0.
// - Transfer interrupt pulses at start of every header and data block.
// - Byte written before current byte ends continues without gap.
// - Missed refill sets underrun, stops, error interrupt, goes to idle state.
// - Each completed received byte passes through the FIFO into receive buffer, or straight from the shift register on overrun.
// - New byte before previous read, with the FIFO also full, sets overrun and overwrites buffer.
// - Reset clears transmit buffer, receive buffer and control register zero.
// - Control register zero takes single-bit and full-byte writes.
// - Receive buffer is read-only; writes ignored.
// - Transmit buffer readable and writable as a byte.
// - Address select resets to zero; bit 15 reads zero.
`timescale 1ns/1ps
`include "cecab_regs.vh"
module cecab_top (
	input wire clk_i,
	input wire reset_i,
	input wire [15:0] addr_i,
	input wire wr_i,
	input wire rd_i,
	input wire wide_i,
	input wire bit_wr_i,
	input wire [2:0] bit_idx_i,
	input wire [15:0] wdata_i,
	output reg [15:0] rdata_o,
	input wire tx_bit_req_i,
	output reg tx_bit_o,
	output reg tx_active_o,
	output reg tx_last_o,
	input wire rx_frame_start_i,
	input wire rx_bit_valid_i,
	input wire rx_bit_i,
	output reg addr_match_o,
	output reg xfer_irq_o,
	output reg err_irq_o,
	output reg cec_enable_o,
	output reg ack_check_o,
	output reg [2:0] clk_sel_o,
	output reg rx_accept_o
);
	localparam ST_IDLE = 2'b01;
	localparam ST_SEND = 2'b10;

	reg [14:0] sel_q;
	reg [7:0] ctrl_q;
	reg [7:0] txbuf_q;
	reg [7:0] rxbuf_q;
	reg rx_full_q;
	reg under_q;
	reg over_q;
	reg [1:0] st_q;
	reg [7:0] tx_sh_q;
	reg [3:0] tx_cnt_q;
	reg tx_first_q;
	reg tx_fresh_q;
	reg [6:0] rx_sh_q;
	reg [3:0] rx_cnt_q;
	reg rx_hdr_q;
	reg [15:0] rd_d;
	reg [7:0] ctrl_d;
	wire wr_sel_lo;
	wire wr_sel_hi;
	wire wr_ctrl;
	wire wr_tx;
	wire wr_stat;
	wire rd_rx;
	wire trig;
	wire byte_done;
	wire [7:0] rx_byte;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire ovr_now;
	wire pop;
	wire tx_load;
	wire tx_under;

	////////////////////////////////////////////////////////////////
	// Register decode; bit writes only land on control zero
	assign wr_sel_lo = wr_i && !bit_wr_i && addr_i == `CECAB_ADDR_SEL_LO;
	assign wr_sel_hi = wr_i && !bit_wr_i && (addr_i == `CECAB_ADDR_SEL_HI || (wide_i && wr_sel_lo));
	assign wr_ctrl = wr_i && addr_i == `CECAB_ADDR_CTRL0;
	assign wr_tx = wr_i && !bit_wr_i && addr_i == `CECAB_ADDR_TXBUF;
	assign wr_stat = wr_i && !bit_wr_i && addr_i == `CECAB_ADDR_STAT;
	assign rd_rx = rd_i && addr_i == `CECAB_ADDR_RXBUF;

	always @* begin
		ctrl_d = ctrl_q;
		if (bit_wr_i) begin
			ctrl_d[bit_idx_i] = wdata_i[0];
		end else begin
			ctrl_d = wdata_i[7:0];
		end
		// Clock select is frozen while the unit runs
		if (ctrl_q[`CECAB_C0_ENABLE]) begin
			ctrl_d[`CECAB_C0_CLK_HI:`CECAB_C0_CLK_LO] = ctrl_q[`CECAB_C0_CLK_HI:`CECAB_C0_CLK_LO];
		end
	end

	// Trigger only counts while enabled and idle
	assign trig = wr_ctrl && ctrl_d[`CECAB_C0_TXTRIG] && ctrl_d[`CECAB_C0_ENABLE] && st_q[0];

	// Control and buffers cleared at reset
	always @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_q <= `CECAB_RST_BYTE;
			txbuf_q <= `CECAB_RST_BYTE;
			sel_q <= `CECAB_RST_SEL;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= ctrl_d;
				// Trigger is a strobe, it never stays set
				ctrl_q[`CECAB_C0_TXTRIG] <= 1'b0;
			end
			if (wr_tx) begin
				txbuf_q <= wdata_i[7:0];
			end
			if (wr_sel_lo) begin
				sel_q[7:0] <= wdata_i[7:0];
			end
			if (wr_sel_hi) begin
				sel_q[14:8] <= wide_i ? wdata_i[14:8] : wdata_i[6:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Transmit sequencer
	assign tx_load = st_q[1] && tx_bit_req_i && tx_cnt_q == `CECAB_CNT_ZERO;
	assign tx_under = tx_load && !tx_first_q && !tx_fresh_q;

	always @(posedge clk_i) begin
		if (reset_i) begin
			st_q <= ST_IDLE;
			tx_sh_q <= `CECAB_RST_BYTE;
			tx_cnt_q <= `CECAB_CNT_ZERO;
			tx_first_q <= 1'b0;
			tx_fresh_q <= 1'b0;
			tx_bit_o <= 1'b0;
			tx_last_o <= 1'b0;
			xfer_irq_o <= 1'b0;
			err_irq_o <= 1'b0;
		end else begin
			xfer_irq_o <= 1'b0;
			err_irq_o <= 1'b0;
			// A write in the load cycle counts as refill for the next block
			if (wr_tx) begin
				tx_fresh_q <= 1'b1;
			end else if (tx_load) begin
				tx_fresh_q <= 1'b0;
			end
			case (st_q)
				ST_IDLE: begin
					if (trig) begin
						st_q <= ST_SEND;
						tx_cnt_q <= `CECAB_CNT_ZERO;
						tx_first_q <= 1'b1;
					end
				end
				ST_SEND: begin
					if (!ctrl_q[`CECAB_C0_ENABLE]) begin
						st_q <= ST_IDLE;
					end else if (tx_under) begin
						st_q <= ST_IDLE;
						err_irq_o <= 1'b1;
					end else if (tx_load) begin
						xfer_irq_o <= 1'b1;
						tx_bit_o <= txbuf_q[7];
						tx_sh_q <= {txbuf_q[6:0], 1'b0};
						tx_cnt_q <= `CECAB_BITS_LAST;
						tx_first_q <= 1'b0;
						tx_last_o <= ctrl_q[`CECAB_C0_EOM];
					end else if (tx_bit_req_i) begin
						tx_bit_o <= tx_sh_q[7];
						tx_sh_q <= {tx_sh_q[6:0], 1'b0};
						tx_cnt_q <= tx_cnt_q - `CECAB_CNT_ONE;
						// Non-final byte rolls into next load with no gap
						if (tx_cnt_q == `CECAB_CNT_ONE && tx_last_o) begin
							st_q <= ST_IDLE;
						end
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Receive shifter, most significant bit first
	assign byte_done = rx_bit_valid_i && ctrl_q[`CECAB_C0_ENABLE] && rx_cnt_q == `CECAB_BITS_LAST;
	assign rx_byte = {rx_sh_q, rx_bit_i};
	// Overrun only once the FIFO itself cannot take the byte
	assign ovr_now = byte_done && !fifo_in_ready;
	assign pop = fifo_out_valid && !rx_full_q && !ovr_now;

	always @(posedge clk_i) begin
		if (reset_i) begin
			rx_sh_q <= 7'h00;
			rx_cnt_q <= `CECAB_CNT_ZERO;
			rx_hdr_q <= 1'b0;
			addr_match_o <= 1'b0;
		end else if (rx_frame_start_i) begin
			rx_cnt_q <= `CECAB_CNT_ZERO;
			rx_hdr_q <= 1'b1;
			addr_match_o <= 1'b0;
		end else if (rx_bit_valid_i && ctrl_q[`CECAB_C0_ENABLE]) begin
			rx_sh_q <= rx_byte[6:0];
			rx_cnt_q <= byte_done ? `CECAB_CNT_ZERO : rx_cnt_q + `CECAB_CNT_ONE;
			if (byte_done && rx_hdr_q) begin
				rx_hdr_q <= 1'b0;
				if (rx_byte[3:0] == `CECAB_UNREG_ADDR) begin
					addr_match_o <= (sel_q == `CECAB_RST_SEL);
				end else begin
					// Bit n marks address n local
					addr_match_o <= sel_q[rx_byte[3:0]];
				end
			end
		end
	end

	// Four bytes of slack between shifter and buffer
	cecab_fifo #(
		.W(`CECAB_FIFO_W),
		.D(`CECAB_FIFO_D),
		.AW(`CECAB_FIFO_AW)
	) u_rx_fifo (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.in_valid_i(byte_done),
		.in_ready_o(fifo_in_ready),
		.in_data_i(rx_byte),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(!rx_full_q && !ovr_now),
		.out_data_o(fifo_out_data)
	);

	// Receive buffer loads from the FIFO, or from the shift path on overrun
	always @(posedge clk_i) begin
		if (reset_i) begin
			rxbuf_q <= `CECAB_RST_BYTE;
			rx_full_q <= 1'b0;
		end else if (ovr_now) begin
			rxbuf_q <= rx_byte;
			rx_full_q <= 1'b1;
		end else if (pop) begin
			rxbuf_q <= fifo_out_data;
			rx_full_q <= 1'b1;
		end else if (rd_rx) begin
			rx_full_q <= 1'b0;
		end
	end

	// Sticky flags; a set in the clear cycle wins
	always @(posedge clk_i) begin
		if (reset_i) begin
			under_q <= 1'b0;
			over_q <= 1'b0;
		end else begin
			if (tx_under) begin
				under_q <= 1'b1;
			end else if (wr_stat && wdata_i[`CECAB_ST_UNDER]) begin
				under_q <= 1'b0;
			end
			if (ovr_now) begin
				over_q <= 1'b1;
			end else if (wr_stat && wdata_i[`CECAB_ST_OVER]) begin
				over_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero
	always @* begin
		rd_d = `CECAB_RST_WORD;
		case (addr_i)
			`CECAB_ADDR_SEL_LO: rd_d = wide_i ? {1'b0, sel_q} : {8'h00, sel_q[7:0]};
			`CECAB_ADDR_SEL_HI: rd_d = {8'h00, 1'b0, sel_q[14:8]};
			`CECAB_ADDR_CTRL0: rd_d = {8'h00, ctrl_q};
			`CECAB_ADDR_TXBUF: rd_d = {8'h00, txbuf_q};
			// Read-only buffer, no write path decoded
			`CECAB_ADDR_RXBUF: rd_d = {8'h00, rxbuf_q};
			`CECAB_ADDR_STAT: rd_d = {12'h000, rx_full_q, st_q[1], over_q, under_q};
			default: rd_d = `CECAB_RST_WORD;
		endcase
	end

	// Registered outputs
	always @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= `CECAB_RST_WORD;
			tx_active_o <= 1'b0;
			cec_enable_o <= 1'b0;
			ack_check_o <= 1'b0;
			clk_sel_o <= 3'h0;
			rx_accept_o <= 1'b0;
		end else begin
			if (rd_i) begin
				rdata_o <= rd_d;
			end
			tx_active_o <= st_q[1];
			cec_enable_o <= ctrl_q[`CECAB_C0_ENABLE];
			ack_check_o <= ctrl_q[`CECAB_C0_ACKCHK];
			clk_sel_o <= ctrl_q[`CECAB_C0_CLK_HI:`CECAB_C0_CLK_LO];
			rx_accept_o <= ctrl_q[`CECAB_C0_RXACC];
		end
	end
endmodule

/* sim/cecab_top_assertions.sv */
`timescale 1ns/1ps
module cecab_top_assertions (
	input wire clk_i,
	input wire reset_i,
	input wire wr_i,
	input wire rd_i,
	input wire tx_bit_req_i,
	input wire rx_frame_start_i,
	input wire rx_bit_valid_i,
	input wire [15:0] rdata_o,
	input wire tx_bit_o,
	input wire tx_active_o,
	input wire xfer_irq_o,
	input wire err_irq_o,
	input wire addr_match_o,
	input wire cec_enable_o,
	input wire [2:0] clk_sel_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	////////////////////////////////////////
	// irq needs request
	property p_irq; xfer_irq_o |-> $past(tx_bit_req_i); endproperty
	a_irq: assert property (p_irq) else $error("xfer irq without bit request");
	property p_err; err_irq_o |-> $past(tx_bit_req_i) && !xfer_irq_o; endproperty
	a_err: assert property (p_err) else $error("error irq out of place");
	property p_stop; err_irq_o |-> ##[1:2] !tx_active_o; endproperty
	a_stop: assert property (p_stop) else $error("send went on after underrun");
	property p_bit; !$past(tx_bit_req_i) |-> $stable(tx_bit_o); endproperty
	a_bit: assert property (p_bit) else $error("tx bit moved without request");
	property p_rd; !$past(rd_i) |-> $stable(rdata_o); endproperty
	a_rd: assert property (p_rd) else $error("read data moved without read");
	property p_clk; $changed(clk_sel_o) |-> !$past(cec_enable_o); endproperty
	a_clk: assert property (p_clk) else $error("clock select changed while enabled");
	property p_go; $rose(tx_active_o) |-> $past(wr_i, 2); endproperty
	a_go: assert property (p_go) else $error("send began without write");
	// match follows the last header bit by one edge
	property p_hit; $rose(addr_match_o) |-> $past(rx_bit_valid_i); endproperty
	a_hit: assert property (p_hit) else $error("match without header byte");
	property p_clr; rx_frame_start_i |=> !addr_match_o; endproperty
	a_clr: assert property (p_clr) else $error("match kept over frame start");
	// Main scenarios reached
	c_irq: cover property (xfer_irq_o);
	c_err: cover property (err_irq_o);
	c_hit: cover property ($rose(addr_match_o));
	c_end: cover property ($fell(tx_active_o));
endmodule

/* sim/cecab_node.sv */
`timescale 1ns/1ps
module cecab_node (
	input wire clk_i,
	input wire tx_bit_i,
	input wire irq_i,
	input wire err_i,
	output reg bit_req_o,
	output reg frame_o,
	output reg valid_o,
	output reg data_o
);
	integer k;
	// Idle bus side
	initial begin
		bit_req_o = 1'b0;
		frame_o = 1'b0;
		valid_o = 1'b0;
		data_o = 1'b0;
	end
	////////////////////////////////////////
	// One-cycle frame start pulse
	task frame;
		begin
			@(posedge clk_i);
			#1 frame_o = 1'b1;
			@(posedge clk_i);
			#1 frame_o = 1'b0;
		end
	endtask
	task send_byte(input [7:0] b);
		begin
			for (k = 7; k >= 0; k = k - 1) begin
				@(posedge clk_i);
				#1 valid_o = 1'b1;
				data_o = b[k];
				@(posedge clk_i);
				// Line shows inverse after the bit, not a stale copy
				#1 valid_o = 1'b0;
				data_o = ~b[k];
			end
			repeat (3) @(posedge clk_i);
			#1;
		end
	endtask
	task pull_byte(output [7:0] b, output [3:0] irqs, output e);
		begin
			irqs = 4'h0;
			e = 1'b0;
			for (k = 7; k >= 0; k = k - 1) begin
				@(posedge clk_i);
				#1 bit_req_o = 1'b1;
				@(posedge clk_i);
				#1 bit_req_o = 1'b0;
				b[k] = tx_bit_i;
				irqs = irqs + {3'h0, irq_i};
				e = e | err_i;
			end
		end
	endtask
endmodule

/* sim/tb_cecab_top.sv */
`timescale 1ns/1ps
`include "cecab_regs.vh"
module tb_cecab_top;
	reg clk_i = 1'b0;
	reg reset_i = 1'b1;
	reg [15:0] addr_i = 16'h0000;
	reg wr_i = 1'b0;
	reg rd_i = 1'b0;
	reg wide_i = 1'b0;
	reg bit_wr_i = 1'b0;
	reg [2:0] bit_idx_i = 3'h0;
	reg [15:0] wdata_i = 16'h0000;
	wire [15:0] rdata_o;
	wire tx_bit_req_i, tx_bit_o, tx_active_o, tx_last_o, rx_frame_start_i, rx_bit_valid_i, rx_bit_i;
	wire addr_match_o, xfer_irq_o, err_irq_o, cec_enable_o, ack_check_o, rx_accept_o;
	wire [2:0] clk_sel_o;
	integer errors = 0;
	integer check_count = 0;
	integer n;
	reg [15:0] v;
	reg [7:0] b;
	reg [3:0] q;
	reg e;
	// 125 MHz clock
	always #4 clk_i = ~clk_i;
	cecab_top dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
		.wide_i(wide_i), .bit_wr_i(bit_wr_i), .bit_idx_i(bit_idx_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
		.tx_bit_req_i(tx_bit_req_i), .tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o), .tx_last_o(tx_last_o),
		.rx_frame_start_i(rx_frame_start_i), .rx_bit_valid_i(rx_bit_valid_i), .rx_bit_i(rx_bit_i),
		.addr_match_o(addr_match_o), .xfer_irq_o(xfer_irq_o), .err_irq_o(err_irq_o),
		.cec_enable_o(cec_enable_o), .ack_check_o(ack_check_o), .clk_sel_o(clk_sel_o), .rx_accept_o(rx_accept_o));
	cecab_node node (.clk_i(clk_i), .tx_bit_i(tx_bit_o), .irq_i(xfer_irq_o), .err_i(err_irq_o),
		.bit_req_o(tx_bit_req_i), .frame_o(rx_frame_start_i), .valid_o(rx_bit_valid_i), .data_o(rx_bit_i));
	////////////////////////////////////////
	task wrap_up;
		begin
			if (errors == 0 && check_count > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input [127:0] nm, input [15:0] seen, input [15:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("[ERR] %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// Write: m[0] wide, m[1] single bit at d[10:8] with value d[0]
	task wr(input [15:0] a, input [15:0] d, input [1:0] m);
		begin
			@(posedge clk_i);
			#1 addr_i = a;
			wdata_i = d;
			wide_i = m[0];
			bit_wr_i = m[1];
			bit_idx_i = d[10:8];
			wr_i = 1'b1;
			@(posedge clk_i);
			#1 wr_i = 1'b0;
			bit_wr_i = 1'b0;
			wide_i = 1'b0;
		end
	endtask
	task rd(input [15:0] a, input w, output [15:0] d);
		begin
			@(posedge clk_i);
			#1 addr_i = a;
			wide_i = w;
			rd_i = 1'b1;
			@(posedge clk_i);
			#1 rd_i = 1'b0;
			wide_i = 1'b0;
			d = rdata_o;
		end
	endtask
	// Reset held five cycles, then transmit, receive, control and select registers read zero
	task reset_chk;
		begin
			@(posedge clk_i);
			#1 reset_i = 1'b1;
			repeat (5) @(posedge clk_i);
			#1 reset_i = 1'b0;
			rd(`CECAB_ADDR_TXBUF, 1'b0, v);
			chk("txbuf", v, 16'h0000);
			rd(`CECAB_ADDR_RXBUF, 1'b0, v);
			chk("rxbuf", v, 16'h0000);
			rd(`CECAB_ADDR_CTRL0, 1'b0, v);
			chk("ctrl0", v, 16'h0000);
			rd(`CECAB_ADDR_SEL_LO, 1'b1, v);
			chk("sel", v, 16'h0000);
		end
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_i);
		errors = errors + 1;
		wrap_up;
	end
	initial begin
		reset_chk;
		wr(`CECAB_ADDR_TXBUF, 16'h0055, 2'b00);
		rd(`CECAB_ADDR_TXBUF, 1'b0, v);
		chk("txbuf rw", v, 16'h0055);
		wr(`CECAB_ADDR_RXBUF, 16'h00aa, 2'b00);
		rd(`CECAB_ADDR_RXBUF, 1'b0, v);
		chk("rxbuf ro", v, 16'h0000);
		wr(`CECAB_ADDR_CTRL0, 16'h0701, 2'b10);
		rd(`CECAB_ADDR_CTRL0, 1'b0, v);
		chk("bit write", v, 16'h0080);
		chk("enable pin", {15'h0000, cec_enable_o}, 16'h0001);
		node.frame();
		node.send_byte(8'ha5);
		rd(`CECAB_ADDR_RXBUF, 1'b0, v);
		chk("rx byte", v, 16'h00a5);
		// Five bytes fill buffer and FIFO, the sixth overruns
		for (n = 0; n < 6; n = n + 1)
			node.send_byte(8'h10 + n[7:0]);
		rd(`CECAB_ADDR_RXBUF, 1'b0, v);
		chk("overwrite", v, 16'h0015);
		rd(`CECAB_ADDR_STAT, 1'b0, v);
		chk("overrun", v & 16'h0002, 16'h0002);
		wr(`CECAB_ADDR_TXBUF, 16'h00c3, 2'b00);
		wr(`CECAB_ADDR_CTRL0, 16'h0084, 2'b00);
		node.pull_byte(b, q, e);
		chk("tx byte", {8'h00, b}, 16'h00c3);
		chk("irq count", {12'h000, q}, 16'h0001);
		wr(`CECAB_ADDR_TXBUF, 16'h003c, 2'b00);
		node.pull_byte(b, q, e);
		chk("tx next", {8'h00, b}, 16'h003c);
		chk("tx on", {15'h0000, tx_active_o}, 16'h0001);
		node.pull_byte(b, q, e);
		chk("err irq", {15'h0000, e}, 16'h0001);
		rd(`CECAB_ADDR_STAT, 1'b0, v);
		chk("underrun", v & 16'h0005, 16'h0001);
		// Closing byte with end-of-message set stops after bit 0
		wr(`CECAB_ADDR_TXBUF, 16'h0081, 2'b00);
		wr(`CECAB_ADDR_CTRL0, 16'h0085, 2'b00);
		node.pull_byte(b, q, e);
		chk("tx last byte", {8'h00, b}, 16'h0081);
		chk("eom pin", {15'h0000, tx_last_o}, 16'h0001);
		rd(`CECAB_ADDR_STAT, 1'b0, v);
		chk("tx stopped", v & 16'h0004, 16'h0000);
		// Writing ones clears both sticky flags
		wr(`CECAB_ADDR_STAT, 16'h0003, 2'b00);
		rd(`CECAB_ADDR_STAT, 1'b0, v);
		chk("flags clear", v & 16'h0003, 16'h0000);
		reset_chk;
		// Clock select taken while stopped, frozen once enabled
		wr(`CECAB_ADDR_CTRL0, 16'h00ea, 2'b00);
		rd(`CECAB_ADDR_CTRL0, 1'b0, v);
		chk("ctrl byte", v, 16'h00ea);
		chk("ctrl pins", {10'h000, cec_enable_o, ack_check_o, clk_sel_o, rx_accept_o}, 16'h003b);
		wr(`CECAB_ADDR_CTRL0, 16'h0080, 2'b00);
		rd(`CECAB_ADDR_CTRL0, 1'b0, v);
		chk("clk frozen", v, 16'h00a8);
		chk("clk pins", {13'h0000, clk_sel_o}, 16'h0005);
		for (n = 8; n < 15; n = n + 1) begin
			wr(`CECAB_ADDR_SEL_LO, 16'h0001 << n, 2'b01);
			node.frame();
			node.send_byte({4'h4, n[3:0]});
			chk("own addr", {15'h0000, addr_match_o}, 16'h0001);
			node.frame();
			node.send_byte({4'h4, n[3:0] - 4'h1});
			chk("other addr", {15'h0000, addr_match_o}, 16'h0000);
		end
		wr(`CECAB_ADDR_SEL_LO, 16'hffff, 2'b01);
		rd(`CECAB_ADDR_SEL_LO, 1'b1, v);
		chk("sel msb", v, 16'h7fff);
		wr(`CECAB_ADDR_SEL_LO, 16'h0000, 2'b01);
		node.frame();
		node.send_byte(8'h4f);
		chk("addr 15", {15'h0000, addr_match_o}, 16'h0001);
		wrap_up;
	end
endmodule
bind cecab_top cecab_top_assertions chk_i (.clk_i(clk_i), .reset_i(reset_i), .wr_i(wr_i), .rd_i(rd_i),
	.tx_bit_req_i(tx_bit_req_i), .rx_frame_start_i(rx_frame_start_i), .rx_bit_valid_i(rx_bit_valid_i),
	.rdata_o(rdata_o), .tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o), .xfer_irq_o(xfer_irq_o),
	.err_irq_o(err_irq_o), .addr_match_o(addr_match_o), .cec_enable_o(cec_enable_o), .clk_sel_o(clk_sel_o));
